// ===== hw/irq_if.sv
// Interface between register block and interrupt evaluator.
`default_nettype none
interface irq_if;
  logic [3:0] mask; // Enabled sources
  logic [3:0] cond; // Raw source conditions
  logic [5:0] code; // Highest pending source code
  logic       any;  // Any enabled source pending
  modport evaluator (input mask, input cond,
                     output code, output any);
  modport owner (output mask, output cond,
                 input code, input any);
endinterface : irq_if
`default_nettype wire

// ===== hw/irq_prio.sv
// Masks interrupt conditions and picks the reported source.
`default_nettype none
module irq_prio (
  // Register block side
  irq_if.evaluator bus
);
  // ----------------------------------------------------------
  // Masking and priority
  // ----------------------------------------------------------
  logic [3:0] pend; // Conditions passing the mask

  // Gate each source by its mask bit
  always_comb begin
    pend = bus.mask & bus.cond;
  end

  // Line status first, modem status last
  always_comb begin
    bus.any = |pend;
    if (pend[uart_regs_pkg::MSK_LS]) begin
      bus.code = uart_regs_pkg::SRC_LINE;
    end else if (pend[uart_regs_pkg::MSK_RX]) begin
      bus.code = uart_regs_pkg::SRC_RXDAT;
    end else if (pend[uart_regs_pkg::MSK_TX]) begin
      bus.code = uart_regs_pkg::SRC_TXRDY;
    end else if (pend[uart_regs_pkg::MSK_MS]) begin
      bus.code = uart_regs_pkg::SRC_MODEM;
    end else begin
      bus.code = uart_regs_pkg::SRC_NONE;
    end
  end
endmodule : irq_prio
`default_nettype wire

// ===== hw/uart_ier_ext_regs.sv
// Mask, line state and enhanced registers of one channel.
`default_nettype none
module uart_ier_ext_regs #(
  parameter logic [7:0] REV_CODE = 8'hA5, // Arbitrary value
  parameter logic [7:0] DEV_ID   = 8'h5A  // Arbitrary value
) (
  // Clock and reset
  input  wire  logic        CLK,
  input  wire  logic        NRST,
  // Host bus
  input  wire  logic [2:0]  ADDR,
  input  wire  logic        WR_STB,
  input  wire  logic        RD_STB,
  input  wire  logic [7:0]  WDATA,
  output logic       [7:0]  RDATA,
  output logic              RDATA_HIT,
  // Channel configuration
  input  wire  logic [7:0]  LCR_VALUE,
  input  wire  logic        FIFO_ENABLE,
  input  wire  logic [7:0]  DIV_LOW,
  input  wire  logic [7:0]  DIV_HIGH,
  // Receive side
  input  wire  logic        RX_PUSH,
  input  wire  logic [7:0]  RX_FILL,
  input  wire  logic        RX_OVERRUN,
  input  wire  logic        HEAD_PARITY_ERR,
  input  wire  logic        HEAD_FRAMING_ERR,
  input  wire  logic        HEAD_BREAK,
  input  wire  logic        RX_FIFO_ERR_ANY,
  // Transmit side
  input  wire  logic [7:0]  TX_FILL,
  input  wire  logic        THR_EMPTY,
  input  wire  logic        TSR_EMPTY,
  // Modem status
  input  wire  logic        MODEM_DELTA,
  // Outputs to the channel
  output logic              IRQ,
  output logic       [3:0]  EXT_MASK,
  output logic       [7:0]  FEATURE_CTRL,
  output logic       [7:0]  ENH_FUNC,
  output logic       [7:0]  RX_TRIG,
  output logic       [7:0]  TX_TRIG,
  output logic       [31:0] FLOW_CHARS
);
  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  // Fill count compared with a trigger level
  function automatic logic reached(input logic [7:0] fill,
                                   input logic [7:0] trig);
    reached = (fill >= trig);
  endfunction : reached

  // ----------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------
  irq_if irq_bus (); // Link to the evaluator

  logic [7:0] mask_reg;      // Interrupt mask storage
  logic [7:0] feature_reg;   // Feature control
  logic [7:0] enh_reg;       // Enhanced function
  logic [7:0] rx_trig_reg;   // Receive trigger level
  logic [7:0] tx_trig_reg;   // Transmit trigger level
  logic [7:0] res1_reg;      // Resume char one
  logic [7:0] res2_reg;      // Resume char two
  logic [7:0] pau1_reg;      // Pause char one
  logic [7:0] pau2_reg;      // Pause char two
  logic       ready_reg;     // Receive data ready
  logic       overrun_reg;   // Sticky overrun
  logic       tx_pend_reg;   // Transmit ready pending
  logic       thr_empty_reg; // Delayed holding empty
  logic       tx_below_reg;  // Delayed fifo below trigger
  logic       irq_reg;       // Registered interrupt
  logic [7:0] rdata_reg;     // Read data
  logic       hit_reg;       // Read decoded
  logic [7:0] rdata_next;    // Read mux
  logic       hit_next;      // Read mux decode

  logic       enh_mode;      // Enhanced set selected
  logic       div_mode;      // Divisor access, not enhanced
  logic       norm_mode;     // Ordinary register set
  logic       unlocked;      // Extended bits enabled
  logic       id_mode;       // Identity codes visible
  logic [7:0] mask_eff;      // Mask as seen by logic
  logic [7:0] line_state;    // Line state value
  logic [7:0] isrc_value;    // Interrupt source value
  logic       rx_cond;       // Receive data condition
  logic       ls_cond;       // Line status condition
  logic       tx_below;      // Tx fifo under trigger
  logic       wr_enh;        // Write to enhanced set
  logic       wr_mask;       // Write to mask
  logic       wr_hold;       // Write to tx holding
  logic       rd_line;       // Read of line state
  logic       rd_isrc;       // Read of interrupt source
  logic       tx_set;        // Transmit ready event

  // ----------------------------------------------------------
  // Address space selection
  // ----------------------------------------------------------
  // Mode follows the line control value
  always_comb begin
    enh_mode  = (LCR_VALUE == uart_regs_pkg::LCR_ENH_KEY);
    div_mode  = LCR_VALUE[uart_regs_pkg::LCR_DIV_BIT] &&
                !enh_mode;
    norm_mode = !LCR_VALUE[uart_regs_pkg::LCR_DIV_BIT];
    id_mode   = div_mode && (DIV_LOW == 8'h00) &&
                (DIV_HIGH == 8'h00);
    unlocked  = enh_reg[uart_regs_pkg::EFN_UNLOCK];
  end

  // Strobe qualification
  always_comb begin
    wr_enh  = WR_STB && enh_mode;
    wr_mask = WR_STB && norm_mode &&
              (ADDR == uart_regs_pkg::ADDR_MASK);
    wr_hold = WR_STB && norm_mode &&
              (ADDR == uart_regs_pkg::ADDR_HOLD);
    rd_line = RD_STB && norm_mode &&
              (ADDR == uart_regs_pkg::ADDR_LSTAT);
    rd_isrc = RD_STB && norm_mode &&
              (ADDR == uart_regs_pkg::ADDR_ISRC);
  end

  // ----------------------------------------------------------
  // Interrupt mask
  // ----------------------------------------------------------
  // Low bits always writable; high bits need unlock
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      mask_reg <= uart_regs_pkg::REG_RST;
    end else if (wr_mask) begin
      mask_reg[3:0] <= WDATA[3:0];
      if (unlocked) begin
        mask_reg[7:4] <= WDATA[7:4];
      end
    end
  end

  // Locked high bits act as zero
  always_comb begin
    mask_eff = {mask_reg[7:4] & {4{unlocked}},
                mask_reg[3:0]};
  end

  // ----------------------------------------------------------
  // Enhanced register set
  // ----------------------------------------------------------
  // Feature control, enhanced function and flow chars
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      feature_reg <= uart_regs_pkg::REG_RST;
      enh_reg     <= uart_regs_pkg::REG_RST;
      res1_reg    <= uart_regs_pkg::REG_RST;
      res2_reg    <= uart_regs_pkg::REG_RST;
      pau1_reg    <= uart_regs_pkg::REG_RST;
      pau2_reg    <= uart_regs_pkg::REG_RST;
    end else if (wr_enh) begin
      case (ADDR)
        uart_regs_pkg::ADDR_FCTL: feature_reg <= WDATA;
        uart_regs_pkg::ADDR_EFN:  enh_reg     <= WDATA;
        uart_regs_pkg::ADDR_RES1: res1_reg    <= WDATA;
        uart_regs_pkg::ADDR_RES2: res2_reg    <= WDATA;
        uart_regs_pkg::ADDR_PAU1: pau1_reg    <= WDATA;
        uart_regs_pkg::ADDR_PAU2: pau2_reg    <= WDATA;
        default: begin
          // Trigger handled below, address 3 unused
        end
      endcase
    end
  end

  // Trigger write lands on side picked by feature bit
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      rx_trig_reg <= uart_regs_pkg::TRIG_RST;
      tx_trig_reg <= uart_regs_pkg::TRIG_RST;
    end else if (wr_enh && (ADDR == uart_regs_pkg::ADDR_TRIG)) begin
      if (feature_reg[uart_regs_pkg::FCTL_RX_SEL]) begin
        rx_trig_reg <= WDATA;
      end else begin
        tx_trig_reg <= WDATA;
      end
    end
  end

  // ----------------------------------------------------------
  // Line state
  // ----------------------------------------------------------
  // Ready on push, cleared at empty; push wins
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      ready_reg <= 1'b0;
    end else if (RX_PUSH) begin
      ready_reg <= 1'b1;
    end else if (RX_FILL == 8'h00) begin
      ready_reg <= 1'b0;
    end
  end

  // Sticky overrun, cleared by line state read
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      overrun_reg <= 1'b0;
    end else if (RX_OVERRUN) begin
      overrun_reg <= 1'b1;
    end else if (rd_line) begin
      overrun_reg <= 1'b0;
    end
  end

  // Assemble the polled status word
  always_comb begin
    line_state = {RX_FIFO_ERR_ANY,
                  THR_EMPTY && TSR_EMPTY,
                  THR_EMPTY,
                  HEAD_BREAK,
                  HEAD_FRAMING_ERR,
                  HEAD_PARITY_ERR,
                  overrun_reg,
                  ready_reg};
  end

  // ----------------------------------------------------------
  // Interrupt conditions
  // ----------------------------------------------------------
  // Receive level in FIFO mode, ready otherwise
  always_comb begin
    rx_cond  = FIFO_ENABLE ? reached(RX_FILL, rx_trig_reg)
                           : ready_reg;
    ls_cond  = |line_state[4:1];
    tx_below = !reached(TX_FILL, tx_trig_reg);
  end

  // Transmit ready events
  always_comb begin
    tx_set = FIFO_ENABLE ? (tx_below && !tx_below_reg)
                         : (THR_EMPTY && !thr_empty_reg);
    if (wr_mask && WDATA[uart_regs_pkg::MSK_TX] &&
        !mask_reg[uart_regs_pkg::MSK_TX] && THR_EMPTY) begin
      tx_set = 1'b1;
    end else if (!mask_reg[uart_regs_pkg::MSK_TX]) begin
      tx_set = 1'b0;
    end
  end

  // Edge history for transmit events
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      thr_empty_reg <= 1'b1;
      tx_below_reg  <= 1'b1;
    end else begin
      thr_empty_reg <= THR_EMPTY;
      tx_below_reg  <= tx_below;
    end
  end

  // Pending transmit ready; a new event beats a clear
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      tx_pend_reg <= 1'b0;
    end else if (tx_set) begin
      tx_pend_reg <= 1'b1;
    end else if (wr_hold || (rd_isrc &&
             irq_bus.code == uart_regs_pkg::SRC_TXRDY)) begin
      tx_pend_reg <= 1'b0;
    end
  end

  // Feed the evaluator
  always_comb begin
    irq_bus.mask = mask_eff[3:0];
    irq_bus.cond = {MODEM_DELTA,
                    ls_cond,
                    tx_pend_reg,
                    rx_cond};
  end

  // Masking and priority pick
  irq_prio u_prio (
    .bus (irq_bus.evaluator)
  );

  // Registered interrupt output
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_bus.any;
    end
  end

  // ----------------------------------------------------------
  // Read path
  // ----------------------------------------------------------
  // Source value with FIFO flags on top
  always_comb begin
    isrc_value = {FIFO_ENABLE, FIFO_ENABLE, irq_bus.code};
  end

  // Decode the read address in the current mode
  always_comb begin
    rdata_next = 8'h00;
    hit_next   = 1'b0;
    if (enh_mode) begin
      hit_next = (ADDR != 3'h3);
      case (ADDR)
        uart_regs_pkg::ADDR_TRIG: rdata_next =
          feature_reg[uart_regs_pkg::FCTL_RX_SEL] ? RX_FILL : TX_FILL;
        uart_regs_pkg::ADDR_FCTL: rdata_next = feature_reg;
        uart_regs_pkg::ADDR_EFN:  rdata_next = enh_reg;
        uart_regs_pkg::ADDR_RES1: rdata_next = res1_reg;
        uart_regs_pkg::ADDR_RES2: rdata_next = res2_reg;
        uart_regs_pkg::ADDR_PAU1: rdata_next = pau1_reg;
        uart_regs_pkg::ADDR_PAU2: rdata_next = pau2_reg;
        default:                  rdata_next = 8'h00;
      endcase
    end else if (id_mode && (ADDR <= 3'h1)) begin
      // Revision at address 0, identifier at address 1
      hit_next   = 1'b1;
      rdata_next = ADDR[0] ? DEV_ID : REV_CODE;
    end else if (norm_mode) begin
      case (ADDR)
        uart_regs_pkg::ADDR_MASK: begin
          hit_next   = 1'b1;
          rdata_next = mask_eff;
        end
        uart_regs_pkg::ADDR_ISRC: begin
          hit_next   = 1'b1;
          rdata_next = isrc_value;
        end
        uart_regs_pkg::ADDR_LSTAT: begin
          hit_next   = 1'b1;
          rdata_next = line_state;
        end
        default: hit_next = 1'b0; // Left to the rest of the channel
      endcase
    end
  end

  // Capture read data on the strobe
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      rdata_reg <= 8'h00;
      hit_reg   <= 1'b0;
    end else begin
      hit_reg <= RD_STB && hit_next;
      if (RD_STB) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  // Drive the ports from registers
  always_comb begin
    RDATA        = rdata_reg;
    RDATA_HIT    = hit_reg;
    IRQ          = irq_reg;
    EXT_MASK     = mask_eff[7:4];
    FEATURE_CTRL = feature_reg;
    ENH_FUNC     = enh_reg;
    RX_TRIG      = rx_trig_reg;
    TX_TRIG      = tx_trig_reg;
    FLOW_CHARS   = {pau2_reg, pau1_reg, res2_reg, res1_reg};
  end
endmodule : uart_ier_ext_regs
`default_nettype wire

// ===== hw/uart_regs_pkg.sv
// Constants shared by the register and interrupt-mask block.
// What this block does
// - Upper mask bits locked unless unlock bit set
// - Mask gates four sources, reported in source
// - FIFO receive interrupt follows trigger threshold
// - Source code tracks trigger, clears below it
// - Data ready set on push, cleared empty
// - All masks clear gives independent polled status
// - Line state bit 1 flags receive overrun
// - Bits 2-4 report head byte errors
// - Bit 5 holding empty, bit 6 all empty
// - Bit 7 flags any errored FIFO character
// - Mask bit 0 drives receive data interrupt
// - Mask bit 1 drives transmit ready interrupt
// - Enabling transmit mask while empty interrupts
// - Mask bit 2 drives line status interrupt
// - Mask bit 3 drives modem status interrupt
// - Mask bits 0-3 zero after reset
`default_nettype none
package uart_regs_pkg;
  // ----------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------
  localparam logic [2:0] ADDR_TRIG  = 3'h0; // Trigger, fill, rev
  localparam logic [2:0] ADDR_FCTL  = 3'h1; // Feature, identifier
  localparam logic [2:0] ADDR_EFN   = 3'h2; // Enhanced function
  localparam logic [2:0] ADDR_RES1  = 3'h4; // Resume char one
  localparam logic [2:0] ADDR_RES2  = 3'h5; // Resume char two
  localparam logic [2:0] ADDR_PAU1  = 3'h6; // Pause char one
  localparam logic [2:0] ADDR_PAU2  = 3'h7; // Pause char two
  localparam logic [2:0] ADDR_HOLD  = 3'h0; // Tx holding write
  localparam logic [2:0] ADDR_MASK  = 3'h1; // Interrupt mask
  localparam logic [2:0] ADDR_ISRC  = 3'h2; // Interrupt source
  localparam logic [2:0] ADDR_LSTAT = 3'h5; // Line state
  localparam logic [7:0] LCR_ENH_KEY = 8'hBF; // Enhanced key
  // ----------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------
  localparam int LCR_DIV_BIT  = 7; // Divisor access enable
  localparam int EFN_UNLOCK   = 4; // Extended feature unlock
  localparam int FCTL_RX_SEL  = 7; // Trigger/count selects rx
  localparam int MSK_RX       = 0;
  localparam int MSK_TX       = 1;
  localparam int MSK_LS       = 2;
  localparam int MSK_MS       = 3;
  localparam int LS_DR        = 0;
  localparam int LS_OE        = 1;
  localparam int LS_THRE      = 5;
  localparam int LS_TEMT      = 6;
  localparam int LS_FERR      = 7;
  // ----------------------------------------------------------
  // Reset values and source codes
  // ----------------------------------------------------------
  localparam logic [7:0] REG_RST   = 8'h00; // Mask, control
  localparam logic [7:0] TRIG_RST  = 8'h01; // Trigger level
  localparam logic [5:0] SRC_LINE  = 6'h06;
  localparam logic [5:0] SRC_RXDAT = 6'h04;
  localparam logic [5:0] SRC_TXRDY = 6'h02;
  localparam logic [5:0] SRC_MODEM = 6'h00;
  localparam logic [5:0] SRC_NONE  = 6'h01;
endpackage : uart_regs_pkg
`default_nettype wire

// ===== tb/host_bus_model.sv
// Host processor model issuing byte reads and writes.
`default_nettype none
module host_bus_model (
  // Clock and answer
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  input  wire logic       rdata_hit,
  // Request lines
  output var  logic [2:0] addr,
  output var  logic       wr_stb,
  output var  logic       rd_stb,
  output var  logic [7:0] wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    addr = 3'h0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    wdata = 8'h00;
  end
  // One-cycle write; released lines show inverted values
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_stb = 1'b1;
    @(negedge clk);
    wr_stb = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask : wr
  // One-cycle read; answer taken while the hit pulse stands
  task automatic rd(input logic [2:0] a, output logic [7:0] d,
                    output logic h);
    @(negedge clk);
    addr = a;
    rd_stb = 1'b1;
    @(negedge clk);
    d = rdata;
    h = rdata_hit;
    rd_stb = 1'b0;
    addr = ~a;
  endtask : rd
endmodule : host_bus_model
`default_nettype wire

// ===== tb/regs_checker.sv
// Bus answer and status checks for the mask and enhanced register block.
`default_nettype none
module regs_checker #(
  parameter logic [7:0] DEV_ID = 8'h00 // Taken from the bound block
) (
  // Clock and reset
  input wire logic       CLK,
  input wire logic       NRST,
  // Host bus
  input wire logic [2:0] ADDR,
  input wire logic       RD_STB,
  input wire logic [7:0] RDATA,
  input wire logic       RDATA_HIT,
  // Channel state
  input wire logic [7:0] LCR_VALUE,
  input wire logic [7:0] DIV_LOW,
  input wire logic [7:0] DIV_HIGH,
  input wire logic       RX_PUSH,
  input wire logic [7:0] RX_FILL,
  input wire logic       RX_OVERRUN,
  input wire logic       HEAD_PARITY_ERR,
  input wire logic       HEAD_FRAMING_ERR,
  input wire logic       HEAD_BREAK,
  input wire logic       RX_FIFO_ERR_ANY,
  input wire logic       THR_EMPTY,
  input wire logic       TSR_EMPTY,
  // Block outputs
  input wire logic       IRQ,
  input wire logic [3:0] EXT_MASK,
  input wire logic [7:0] ENH_FUNC
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  logic ls_rd; // Line state read under normal decode
  assign ls_rd = RD_STB && ADDR == 3'h5 && !LCR_VALUE[7];
  property p_lock; !ENH_FUNC[4] |-> EXT_MASK == 4'h0; endproperty
  a_lock: assert property (p_lock)
    else $error("upper mask visible while locked");
  property p_rst; $rose(NRST) |-> !IRQ ##1 !IRQ; endproperty
  a_rst: assert property (p_rst)
    else $error("interrupt after reset release");
  property p_empty; ls_rd |=> RDATA[5] == $past(THR_EMPTY) &&
    RDATA[6] == ($past(THR_EMPTY) && $past(TSR_EMPTY)); endproperty
  a_empty: assert property (p_empty)
    else $error("transmit empty bits wrong");
  property p_gerr; ls_rd |=> RDATA[7] == $past(RX_FIFO_ERR_ANY); endproperty
  a_gerr: assert property (p_gerr)
    else $error("global error bit wrong");
  property p_head; ls_rd |=> RDATA[4:2] == {$past(HEAD_BREAK),
    $past(HEAD_FRAMING_ERR), $past(HEAD_PARITY_ERR)}; endproperty
  a_head: assert property (p_head)
    else $error("head byte error bits wrong");
  property p_ovr; RX_OVERRUN ##1 ls_rd |=> RDATA[1]; endproperty
  a_ovr: assert property (p_ovr)
    else $error("overrun not reported");
  property p_ready; RX_PUSH ##1 (ls_rd && RX_FILL != 8'h00) |=> RDATA[0];
  endproperty
  a_ready: assert property (p_ready)
    else $error("data ready not set");
  property p_undec; RD_STB && LCR_VALUE != 8'hBF && (ADDR == 3'h3 ||
    ADDR == 3'h4 || ADDR > 3'h5) |=> !RDATA_HIT && RDATA == 8'h00;
  endproperty
  a_undec: assert property (p_undec)
    else $error("foreign address answered");
  sequence s_ident; RD_STB && ADDR == 3'h1 && LCR_VALUE[7] &&
    LCR_VALUE != 8'hBF && DIV_LOW == 8'h00 && DIV_HIGH == 8'h00; endsequence
  property p_ident; s_ident |=> RDATA_HIT && RDATA == DEV_ID; endproperty
  a_ident: assert property (p_ident)
    else $error("identifier read wrong");
  c_ident: cover property (s_ident);
  c_irq: cover property ($rose(IRQ));
  c_unlock: cover property (ENH_FUNC[4] && EXT_MASK != 4'h0);
endmodule : regs_checker
bind uart_ier_ext_regs regs_checker #(.DEV_ID(DEV_ID)) u_chk (.CLK(CLK),
  .NRST(NRST), .ADDR(ADDR), .RD_STB(RD_STB), .RDATA(RDATA),
  .RDATA_HIT(RDATA_HIT), .LCR_VALUE(LCR_VALUE), .DIV_LOW(DIV_LOW),
  .DIV_HIGH(DIV_HIGH), .RX_PUSH(RX_PUSH), .RX_FILL(RX_FILL),
  .RX_OVERRUN(RX_OVERRUN), .HEAD_PARITY_ERR(HEAD_PARITY_ERR),
  .HEAD_FRAMING_ERR(HEAD_FRAMING_ERR), .HEAD_BREAK(HEAD_BREAK),
  .RX_FIFO_ERR_ANY(RX_FIFO_ERR_ANY), .THR_EMPTY(THR_EMPTY),
  .TSR_EMPTY(TSR_EMPTY), .IRQ(IRQ), .EXT_MASK(EXT_MASK),
  .ENH_FUNC(ENH_FUNC));
`default_nettype wire

// ===== tb/uart_interrupt_enable_and_ext_regs_bench.sv
// Self-checking bench of the mask and enhanced register block.
`default_nettype none
module uart_interrupt_enable_and_ext_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] REV = 8'hA5; // Arbitrary value
  localparam logic [7:0] DEV = 8'h5A; // Arbitrary value
  logic clk, nrst, fifo_en, rx_push, rx_ovr, par, frm, brk, gerr;
  logic thr_e, tsr_e, mdelta, wr, rdst, hit, irq, h;
  logic [2:0] addr;
  logic [7:0] line_ctrl_reg, dl, dh, rx_fill, wd, rdata, rtrig, fctl, efn, d, tx_fill;
  logic [3:0] xmask;
  logic [31:0] flow;
  int errors, samples_checked, cycles;
  typedef struct packed {
    logic [7:0] line_ctrl_reg; logic [2:0] a; logic w; logic [7:0] d; logic h;
  } row_s;
  // Line control, address, write, data or expected read, expected hit
  row_s rows [0:20] = '{'{8'h03,3'h1,1'b0,8'h00,1'b1},
    '{8'hBF,3'h2,1'b0,8'h00,1'b1}, '{8'hBF,3'h4,1'b1,8'hA1,1'b0},
    '{8'hBF,3'h5,1'b1,8'hB2,1'b0}, '{8'hBF,3'h6,1'b1,8'hC3,1'b0},
    '{8'hBF,3'h7,1'b1,8'hD4,1'b0}, '{8'hBF,3'h4,1'b0,8'hA1,1'b1},
    '{8'hBF,3'h7,1'b0,8'hD4,1'b1}, '{8'hBF,3'h3,1'b0,8'h00,1'b0},
    '{8'hBF,3'h1,1'b1,8'h81,1'b0}, '{8'hBF,3'h1,1'b0,8'h81,1'b1},
    '{8'hBF,3'h0,1'b0,8'h00,1'b1}, '{8'h03,3'h1,1'b1,8'hFF,1'b0},
    '{8'h03,3'h1,1'b0,8'h0F,1'b1}, '{8'h80,3'h0,1'b0,REV,1'b1},
    '{8'h80,3'h1,1'b0,DEV,1'b1}, '{8'hBF,3'h2,1'b1,8'h10,1'b0},
    '{8'h03,3'h1,1'b0,8'h0F,1'b1}, '{8'h03,3'h1,1'b1,8'hF0,1'b0},
    '{8'h03,3'h2,1'b0,8'h01,1'b1}, '{8'h03,3'h7,1'b0,8'h00,1'b0}};
  uart_ier_ext_regs #(.REV_CODE(REV), .DEV_ID(DEV)) u_dut (.CLK(clk),
    .NRST(nrst), .ADDR(addr), .WR_STB(wr), .RD_STB(rdst), .WDATA(wd),
    .RDATA(rdata), .RDATA_HIT(hit), .LCR_VALUE(line_ctrl_reg), .FIFO_ENABLE(fifo_en),
    .DIV_LOW(dl), .DIV_HIGH(dh), .RX_PUSH(rx_push), .RX_FILL(rx_fill),
    .RX_OVERRUN(rx_ovr), .HEAD_PARITY_ERR(par), .HEAD_FRAMING_ERR(frm),
    .HEAD_BREAK(brk), .RX_FIFO_ERR_ANY(gerr), .TX_FILL(tx_fill),
    .THR_EMPTY(thr_e), .TSR_EMPTY(tsr_e), .MODEM_DELTA(mdelta), .IRQ(irq),
    .EXT_MASK(xmask), .FEATURE_CTRL(fctl), .ENH_FUNC(efn), .RX_TRIG(rtrig),
    .TX_TRIG(), .FLOW_CHARS(flow));
  host_bus_model u_host (.clk(clk), .rdata(rdata), .rdata_hit(hit),
    .addr(addr), .wr_stb(wr), .rd_stb(rdst), .wdata(wd));
  // Compare and count
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Read and expect a decoded answer
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    u_host.rd(a, d, h);
    chk({24'h0, d}, {24'h0, e});
    chk({31'h0, h}, 32'h1);
  endtask : rc
  // Bounded wait for the interrupt level
  task automatic wirq(input logic e);
    for (int i = 0; i < 4 && irq !== e; i++) @(negedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : wirq
  // Verdict and end of run
  task automatic finish_test();
    if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      finish_test();
    end
  end
  // Main sequence
  initial begin
    {nrst, fifo_en, rx_push, rx_ovr, par, frm, brk, gerr} = 8'h00;
    {thr_e, tsr_e, mdelta} = 3'h0;
    {line_ctrl_reg, dl, dh, rx_fill, tx_fill} = {8'h03, 32'h0};
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    foreach (rows[i]) begin
      line_ctrl_reg = rows[i].line_ctrl_reg;
      if (rows[i].w) u_host.wr(rows[i].a, rows[i].d);
      else begin
        u_host.rd(rows[i].a, d, h);
        chk({24'h0, d}, {24'h0, rows[i].d});
        chk({31'h0, h}, {31'h0, rows[i].h});
      end
    end
    chk({flow, fctl, efn, 4'h0, xmask}, 56'hD4C3B2A1_8110_0F);
    // Transmit ready on enable and on holding register emptying
    thr_e = 1'b1;
    u_host.wr(3'h1, 8'h02);
    wirq(1'b1);
    rc(3'h2, 8'h02);
    wirq(1'b0);
    rc(3'h2, 8'h01);
    thr_e = 1'b0;
    @(negedge clk);
    thr_e = 1'b1;
    wirq(1'b1);
    u_host.wr(3'h0, 8'h55);
    wirq(1'b0);
    // Receive threshold in FIFO mode
    fifo_en = 1'b1;
    line_ctrl_reg = 8'hBF;
    u_host.wr(3'h0, 8'h04);
    chk({24'h0, rtrig}, 32'h04);
    line_ctrl_reg = 8'h03;
    u_host.wr(3'h1, 8'h01);
    rx_fill = 8'h03;
    wirq(1'b0);
    rx_fill = 8'h04;
    wirq(1'b1);
    rc(3'h2, 8'hC4);
    rx_fill = 8'h03;
    wirq(1'b0);
    rc(3'h2, 8'hC1);
    // Transmit level falling under its trigger in FIFO mode
    {thr_e, tx_fill} = 9'h002;
    u_host.wr(3'h1, 8'h02);
    tx_fill = 8'h00;
    wirq(1'b1);
    rc(3'h2, 8'hC2);
    thr_e = 1'b1;
    wirq(1'b0);
    // Line status sources
    u_host.wr(3'h1, 8'h04);
    for (int k = 0; k < 3; k++) begin
      {brk, frm, par} = 3'b001 << k;
      wirq(1'b1);
      rc(3'h2, 8'hC6);
      rc(3'h5, 8'h20 | (8'h04 << k));
      {brk, frm, par} = 3'b000;
      wirq(1'b0);
    end
    // Overrun followed at once by a line state read
    rx_ovr = 1'b1;
    fork
      rc(3'h5, 8'h22);
      begin
        @(negedge clk);
        rx_ovr = 1'b0;
      end
    join
    wirq(1'b1);
    rc(3'h5, 8'h20);
    wirq(1'b0);
    // Modem source
    u_host.wr(3'h1, 8'h08);
    mdelta = 1'b1;
    wirq(1'b1);
    rc(3'h2, 8'hC0);
    u_host.wr(3'h1, 8'h00);
    wirq(1'b0);
    mdelta = 1'b0;
    // Polled operation with all sources masked
    rx_fill = 8'h01;
    rx_push = 1'b1;
    fork
      rc(3'h5, 8'hE1);
      begin
        @(negedge clk);
        {rx_push, tsr_e, gerr} = 3'b011;
      end
    join
    chk({31'h0, irq}, 32'h0);
    {rx_fill, gerr} = 9'h000;
    @(negedge clk);
    rc(3'h5, 8'h60);
    // Divisor not zero hides the identifier
    {line_ctrl_reg, dl} = 16'h8001;
    u_host.rd(3'h1, d, h);
    chk({31'h0, h}, 32'h0);
    // Reset in mid-run
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    chk({flow, efn}, 40'h0);
    {nrst, line_ctrl_reg} = 9'h103;
    rc(3'h1, 8'h00);
    finish_test();
  end
endmodule : uart_interrupt_enable_and_ext_regs_bench
`default_nettype wire
